// file: cpu_decode_regs.vh
// Purpose: constants for the branch, bit-test and stop decode block
// Assumes: apb byte addresses, one aligned 32-bit word per register
// Notes: included by every design file of the block
`ifndef CPU_DECODE_REGS_VH
`define CPU_DECODE_REGS_VH

// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_OPCODE 8'h04
`define OFS_OPERAND 8'h08
`define OFS_PC 8'h0c
`define OFS_FLAGS 8'h10
`define OFS_ACC 8'h14
`define OFS_MEM 8'h18
`define OFS_STATUS 8'h1c

// control register fields
`define CTRL_GO 0
`define CTRL_KEEP_MIN 1
`define CTRL_STOP 2
`define CTRL_WAIT 3

// status register fields
`define ST_BUSY 0
`define ST_TAKEN 1
`define ST_ILLEGAL 2
`define ST_DBG_EN 3
`define ST_MODE_LO 4
`define ST_MODE_HI 5
`define ST_SECURE 6
`define ST_OSC 7
`define ST_MINCLK 8

// condition_flags bit positions
`define FLG_C 0
`define FLG_Z 1
`define FLG_N 2
`define FLG_H 4
`define FLG_V 7

// operating modes
`define MODE_RUN 2'h0
`define MODE_WAIT 2'h1
`define MODE_STOP 2'h2
`define MODE_BDM 2'h3

// page-zero and page-9e opcodes, and the page prefixes
`define OPC_CLEAR_MEMORY_BIT_OP_LO 8'h11
`define OPC_CLEAR_MEMORY_BIT_OP_HI 8'h1f
`define OPC_BHI 8'h22
`define OPC_BCC 8'h24
`define OPC_BCS 8'h25
`define OPC_BEQ 8'h27
`define OPC_BRANCH_HALFCARRY_CLEAR_OP 8'h28
`define OPC_BRANCH_HALFCARRY_SET_OP 8'h29
`define OPC_BIL 8'h2e
`define OPC_BIH 8'h2f
`define OPC_ENTER_DEBUG_HALT_OP 8'h82
`define OPC_BGE 8'h90
`define OPC_BGT 8'h92
`define OPC_BIT_IMM 8'ha5
`define OPC_BIT_DIR 8'hb5
`define OPC_BIT_EXT 8'hc5
`define OPC_BIT_IX2 8'hd5
`define OPC_BIT_IX1 8'he5
`define OPC_BIT_IX 8'hf5
`define OPC_PAGE0 8'h00
`define OPC_PAGE_SP 8'h9e
`define OPC_BIT_SP2 8'hd5
`define OPC_BIT_SP1 8'he5

// bus cycle counts
`define CYC_1 3'h1
`define CYC_2 3'h2
`define CYC_3 3'h3
`define CYC_4 3'h4
`define CYC_5 3'h5

// instruction lengths in bytes
`define LEN_1 16'h0001
`define LEN_2 16'h0002
`define LEN_3 16'h0003
`define LEN_4 16'h0004

// execution states
`define EX_IDLE 2'h0
`define EX_RUN 2'h1
`define EX_HOLD 2'h2

`endif

// file: branch_condition_unit.v
// Purpose: evaluates the condition of a relative branch opcode
// Assumes: page-zero opcode, flags and irq level valid in the same cycle
// Notes: purely combinational
`timescale 1ns/1ps
`include "cpu_decode_regs.vh"

module branch_condition_unit (
  input wire [7:0] op,
  input wire [7:0] flags,
  input wire irq_level,
  output reg is_branch,
  output reg taken
);

  wire c = flags[`FLG_C];
  wire z = flags[`FLG_Z];
  wire n = flags[`FLG_N];
  wire h = flags[`FLG_H];
  wire v = flags[`FLG_V];

  // condition decode per opcode
  always @*
  begin
    is_branch = 1'b1;
    taken = 1'b0;
    case (op)
      `OPC_BCS: taken = c;
      `OPC_BEQ: taken = z;
      `OPC_BGE: taken = ~(n ^ v);
      `OPC_BGT: taken = ~(z | (n ^ v));
      `OPC_BRANCH_HALFCARRY_CLEAR_OP: taken = ~h;
      `OPC_BRANCH_HALFCARRY_SET_OP: taken = h;
      `OPC_BHI: taken = ~(c | z);
      `OPC_BCC: taken = ~c;
      `OPC_BIH: taken = irq_level;
      `OPC_BIL: taken = ~irq_level;
      default: is_branch = 1'b0;
    endcase
  end

endmodule

// file: cpu_branch_bittest_stop_decode.v
// Purpose: executes bit-clear, relative branch, bit-test and debug-halt ops; controls stop clocks
// Assumes: apb slave, zero wait state, inputs synchronous to ref_clk
// Notes: software loads opcode, operand, pc, flags, acc and memory byte, then writes go
//
// Overview of operation
// - bit-clear clears bit n of the direct-page byte, leaves flags alone and takes five cycles.
// - branch on carry set and on zero set take a signed offset, three cycles, flags untouched.
// - signed ge branches when n xor v is zero, signed gt when z or (n xor v) is zero.
// - half-carry clear and half-carry set branches each take three cycles.
// - unsigned higher branches when c or z is zero, higher-or-same when c is zero.
// - the pin branches test the sampled irq level, high or low, in three cycles.
// - bit-test ands acc with memory, sets n and z, clears v and changes neither operand.
// - the cpu has run, wait, stop and background operating modes; security is a separate input.
// - by default stop halts every clock, oscillator included, until an external wake.
// - a config bit keeps a minimal clock set alive in stop so a periodic wake works.
// - with debug enabled, by host command or reset into background, the oscillator runs in stop.
// - a host halt while stopped with debug enabled restarts clocks and enters background.
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "cpu_decode_regs.vh"

module cpu_branch_bittest_stop_decode (
  input wire ref_clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire irq_pin,
  input wire wake_event,
  input wire periodic_wake,
  input wire host_halt_cmd,
  input wire host_go_cmd,
  input wire single_step_command,
  input wire tagged_resume_command,
  input wire host_debug_enable_cmd,
  input wire reset_into_background,
  input wire security_active,
  output reg cpu_clk_run,
  output reg osc_run,
  output reg min_clk_run,
  output reg [1:0] cpu_mode,
  output reg exec_done
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  reg [15:0] opcode;
  reg [7:0] operand;
  reg [15:0] pc;
  reg [7:0] condition_flags;
  reg [7:0] acc;
  reg [7:0] mem;
  reg [1:0] ex_state;
  reg [2:0] cnt;
  reg taken;
  reg illegal;
  reg keep_min_clocks;
  reg debug_enable_flag;
  reg started;
  reg [31:0] next_prdata;
  reg next_refuse;

  wire busy = (ex_state != `EX_IDLE);
  wire wr_ok = psel & penable & pready & pwrite & ~pslverr;
  wire resume_cmd = host_go_cmd | single_step_command | tagged_resume_command;
  wire page0 = (opcode[15:8] == `OPC_PAGE0);
  wire [7:0] op_lo = opcode[7:0];
  wire br_is;
  wire br_taken;
  wire is_clear_memory_bit_op = page0 & op_lo[0] & (op_lo >= `OPC_CLEAR_MEMORY_BIT_OP_LO) & (op_lo <= `OPC_CLEAR_MEMORY_BIT_OP_HI);
  wire is_enter_debug_halt_op = page0 & (op_lo == `OPC_ENTER_DEBUG_HALT_OP);
  wire is_branch = page0 & br_is;
  wire last_cycle = (ex_state == `EX_RUN) && (cnt == 3'h0);
  wire enter_debug_halt_op_enter = last_cycle & is_enter_debug_halt_op & debug_enable_flag;
  wire [2:0] bit_sel = op_lo[3:1];
  wire [7:0] bit_res = acc & mem;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // bit-test addressing mode check
  function is_bit_op;
    input [15:0] op;
    begin
      is_bit_op = 1'b0;
      if (op[15:8] == `OPC_PAGE0)
      begin
        case (op[7:0])
          `OPC_BIT_IMM, `OPC_BIT_DIR, `OPC_BIT_EXT,
          `OPC_BIT_IX2, `OPC_BIT_IX1, `OPC_BIT_IX: is_bit_op = 1'b1;
          default: is_bit_op = 1'b0;
        endcase
      end
      else if (op[15:8] == `OPC_PAGE_SP)
      begin
        is_bit_op = (op[7:0] == `OPC_BIT_SP2) || (op[7:0] == `OPC_BIT_SP1);
      end
    end
  endfunction

  // bus cycles of a bit-test opcode
  function [2:0] bit_cycles;
    input [15:0] op;
    begin
      bit_cycles = `CYC_3;
      if (op[15:8] == `OPC_PAGE_SP)
        bit_cycles = (op[7:0] == `OPC_BIT_SP2) ? `CYC_5 : `CYC_4;
      else if (op[7:0] == `OPC_BIT_IMM)
        bit_cycles = `CYC_2;
      else if ((op[7:0] == `OPC_BIT_EXT) || (op[7:0] == `OPC_BIT_IX2))
        bit_cycles = `CYC_4;
    end
  endfunction

  // byte length of a bit-test opcode
  function [15:0] bit_length;
    input [15:0] op;
    begin
      bit_length = `LEN_2;
      if (op[15:8] == `OPC_PAGE_SP)
        bit_length = (op[7:0] == `OPC_BIT_SP2) ? `LEN_4 : `LEN_3;
      else if ((op[7:0] == `OPC_BIT_EXT) || (op[7:0] == `OPC_BIT_IX2))
        bit_length = `LEN_3;
      else if (op[7:0] == `OPC_BIT_IX)
        bit_length = `LEN_1;
    end
  endfunction

  // write-one strobe on a control bit
  function ctrl_strobe;
    input ok;
    input [7:0] addr;
    input bitval;
    begin
      ctrl_strobe = ok & (addr == `OFS_CTRL) & bitval;
    end
  endfunction

  branch_condition_unit u_cond (
    .op(op_lo),
    .flags(condition_flags),
    .irq_level(irq_pin),
    .is_branch(br_is),
    .taken(br_taken)
  );

  wire bit_op = is_bit_op(opcode);
  wire go_wr = ctrl_strobe(wr_ok, paddr, pwdata[`CTRL_GO]);
  wire stop_wr = ctrl_strobe(wr_ok, paddr, pwdata[`CTRL_STOP]);
  wire wait_wr = ctrl_strobe(wr_ok, paddr, pwdata[`CTRL_WAIT]);
  wire [15:0] seq_pc = pc + (is_branch ? `LEN_2 : (is_clear_memory_bit_op ? `LEN_2 :
                       (bit_op ? bit_length(opcode) : `LEN_1)));
  wire [15:0] rel_pc = seq_pc + {{8{operand[7]}}, operand};
  wire [2:0] start_cycles = is_clear_memory_bit_op ? `CYC_5 : (is_branch ? `CYC_3 :
                            (bit_op ? bit_cycles(opcode) : (is_enter_debug_halt_op ? `CYC_5 : `CYC_1)));

  ////////////////////////////////////////////////////////////////////////////
  // apb read mux and refusal check

  // read data and error for the address in setup
  always @*
  begin
    next_prdata = 32'h0000_0000;
    next_refuse = 1'b0;
    case (paddr)
      `OFS_CTRL: next_prdata[`CTRL_KEEP_MIN] = keep_min_clocks;
      `OFS_OPCODE: next_prdata[15:0] = opcode;
      `OFS_OPERAND: next_prdata[7:0] = operand;
      `OFS_PC: next_prdata[15:0] = pc;
      `OFS_FLAGS: next_prdata[7:0] = condition_flags;
      `OFS_ACC: next_prdata[7:0] = acc;
      `OFS_MEM: next_prdata[7:0] = mem;
      `OFS_STATUS:
      begin
        next_prdata[`ST_BUSY] = busy;
        next_prdata[`ST_TAKEN] = taken;
        next_prdata[`ST_ILLEGAL] = illegal;
        next_prdata[`ST_DBG_EN] = debug_enable_flag;
        next_prdata[`ST_MODE_HI:`ST_MODE_LO] = cpu_mode;
        next_prdata[`ST_SECURE] = security_active;
        next_prdata[`ST_OSC] = osc_run;
        next_prdata[`ST_MINCLK] = min_clk_run;
      end
      default: next_refuse = 1'b1;
    endcase
    // execution registers are locked while an instruction runs
    if (pwrite && busy && (paddr != `OFS_STATUS))
      next_refuse = 1'b1;
    // go, stop and wait are accepted only in run mode
    if (pwrite && (paddr == `OFS_CTRL) && (cpu_mode != `MODE_RUN))
      next_refuse = 1'b1;
  end

  // apb handshake, one wait-free access phase
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      if (psel && !penable)
      begin
        prdata <= pwrite ? 32'h0000_0000 : next_prdata;
        pslverr <= next_refuse;
      end
      else if (!psel)
        pslverr <= 1'b0;
    end
  end

  // stop configuration bit
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      keep_min_clocks <= 1'b0;
    else if (wr_ok && paddr == `OFS_CTRL)
      keep_min_clocks <= pwdata[`CTRL_KEEP_MIN];
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction execution

  // load, count bus cycles, retire
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      opcode <= 16'h0000;
      operand <= 8'h00;
      pc <= 16'h0000;
      condition_flags <= 8'h00;
      acc <= 8'h00;
      mem <= 8'h00;
      ex_state <= `EX_IDLE;
      cnt <= 3'h0;
      taken <= 1'b0;
      illegal <= 1'b0;
      exec_done <= 1'b0;
    end
    else
    begin
      exec_done <= 1'b0;
      case (ex_state)
        `EX_IDLE:
        begin
          if (wr_ok)
          begin
            case (paddr)
              `OFS_OPCODE: opcode <= pwdata[15:0];
              `OFS_OPERAND: operand <= pwdata[7:0];
              `OFS_PC: pc <= pwdata[15:0];
              `OFS_FLAGS: condition_flags <= pwdata[7:0];
              `OFS_ACC: acc <= pwdata[7:0];
              `OFS_MEM: mem <= pwdata[7:0];
              default: ;
            endcase
          end
          if (go_wr)
          begin
            ex_state <= `EX_RUN;
            cnt <= start_cycles - 3'h1;
            taken <= 1'b0;
            illegal <= 1'b0;
          end
        end
        `EX_RUN:
        begin
          if (cnt != 3'h0)
            cnt <= cnt - 3'h1;
          else if (enter_debug_halt_op_enter)
            ex_state <= `EX_HOLD;
          else
          begin
            ex_state <= `EX_IDLE;
            exec_done <= 1'b1;
            pc <= seq_pc;
            if (is_clear_memory_bit_op)
              mem[bit_sel] <= 1'b0;
            else if (is_branch)
            begin
              taken <= br_taken;
              if (br_taken)
                pc <= rel_pc;
            end
            else if (bit_op)
            begin
              condition_flags[`FLG_N] <= bit_res[7];
              condition_flags[`FLG_Z] <= (bit_res == 8'h00);
              condition_flags[`FLG_V] <= 1'b0;
            end
            else if (!is_enter_debug_halt_op)
            begin
              illegal <= 1'b1;
              pc <= pc;
            end
          end
        end
        `EX_HOLD:
        begin
          if (resume_cmd)
          begin
            ex_state <= `EX_IDLE;
            exec_done <= 1'b1;
            pc <= seq_pc;
          end
        end
        default: ex_state <= `EX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operating modes and clock control

  // mode sequencing and debug enable
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpu_mode <= `MODE_RUN;
      debug_enable_flag <= 1'b0;
      started <= 1'b0;
    end
    else
    begin
      started <= 1'b1;
      if (!started && reset_into_background)
      begin
        debug_enable_flag <= 1'b1;
        cpu_mode <= `MODE_BDM;
      end
      else
      begin
        if (host_debug_enable_cmd && !security_active)
          debug_enable_flag <= 1'b1;
        case (cpu_mode)
          `MODE_RUN:
          begin
            if (enter_debug_halt_op_enter)
              cpu_mode <= `MODE_BDM;
            else if (host_halt_cmd && debug_enable_flag)
              cpu_mode <= `MODE_BDM;
            else if (stop_wr)
              cpu_mode <= `MODE_STOP;
            else if (wait_wr)
              cpu_mode <= `MODE_WAIT;
          end
          `MODE_WAIT:
          begin
            if (host_halt_cmd && debug_enable_flag)
              cpu_mode <= `MODE_BDM;
            else if (wake_event || periodic_wake)
              cpu_mode <= `MODE_RUN;
          end
          `MODE_STOP:
          begin
            if (host_halt_cmd && debug_enable_flag)
              cpu_mode <= `MODE_BDM;
            else if (wake_event)
              cpu_mode <= `MODE_RUN;
            else if (periodic_wake && keep_min_clocks)
              cpu_mode <= `MODE_RUN;
          end
          `MODE_BDM:
          begin
            if (resume_cmd)
              cpu_mode <= `MODE_RUN;
          end
          default: cpu_mode <= `MODE_RUN;
        endcase
      end
    end
  end

  // clock enables follow the mode
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpu_clk_run <= 1'b1;
      osc_run <= 1'b1;
      min_clk_run <= 1'b1;
    end
    else
    begin
      cpu_clk_run <= (cpu_mode == `MODE_RUN) || (cpu_mode == `MODE_BDM);
      osc_run <= (cpu_mode != `MODE_STOP) || debug_enable_flag;
      min_clk_run <= (cpu_mode != `MODE_STOP) || keep_min_clocks
                     || debug_enable_flag;
    end
  end

endmodule

// file: cpu_decode_sva.sv
// Purpose: port checks for the decode block
// Assumes: one clock domain, async active-low reset
// Notes: bound from the bench top file
`timescale 1ns/1ps
`include "cpu_decode_regs.vh"

module cpu_decode_sva (
  input wire ref_clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire wake_event,
  input wire host_halt_cmd,
  input wire host_go_cmd,
  input wire single_step_command,
  input wire tagged_resume_command,
  input wire cpu_clk_run,
  input wire osc_run,
  input wire min_clk_run,
  input wire [1:0] cpu_mode,
  input wire exec_done
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // bus answer
  rdy_pulse_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle");
  unmapped_err_a: assert property (psel && !penable && paddr > 8'h1c |=> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  status_view_a: assert property (psel && !penable && !pwrite && paddr == `OFS_STATUS
    |=> prdata[5:4] == $past(cpu_mode) && prdata[7] == $past(osc_run))
    else $error("status mode field wrong");
  ////////////////////////////////////////////////////////////////////////////////
  // clocks follow the mode one cycle late
  cpu_clk_a: assert property (cpu_clk_run == ($past(cpu_mode) == `MODE_RUN
    || $past(cpu_mode) == `MODE_BDM))
    else $error("cpu clock wrong for mode");
  osc_stop_a: assert property (!osc_run |-> $past(cpu_mode) == `MODE_STOP)
    else $error("oscillator off outside stop");
  min_clk_a: assert property (!min_clk_run |-> !osc_run)
    else $error("minimal clocks off with oscillator on");
  ////////////////////////////////////////////////////////////////////////////////
  // mode changes
  halt_wake_a: assert property (cpu_mode == `MODE_STOP && $past(cpu_mode) == `MODE_STOP
    && osc_run && host_halt_cmd |-> ##[1:2] cpu_mode == `MODE_BDM)
    else $error("host halt did not enter background");
  resume_run_a: assert property (cpu_mode == `MODE_BDM
    && (host_go_cmd || single_step_command || tagged_resume_command)
    |-> ##[1:2] cpu_mode == `MODE_RUN)
    else $error("resume did not leave background");
  wake_stop_a: assert property (cpu_mode == `MODE_STOP && wake_event && !host_halt_cmd
    |-> ##[1:2] cpu_mode == `MODE_RUN)
    else $error("wake did not leave stop");
  cov_bdm: cover property (cpu_mode == `MODE_BDM ##1 exec_done);
  cov_stop_osc: cover property ($past(cpu_mode) == `MODE_STOP && osc_run);
  cov_err: cover property (pready && pslverr);
endmodule

// file: host_debug_model.sv
// Purpose: host debug system issuing serial command pulses
// Assumes: commands arrive as one-cycle pulses on ref_clk
// Notes: k selects 0 halt, 1 go, 2 step, 3 tagged resume, 4 enable
`timescale 1ns/1ps

module host_debug_model (
  input wire ref_clk,
  output wire host_halt_cmd,
  output wire host_go_cmd,
  output wire single_step_command,
  output wire tagged_resume_command,
  output wire host_debug_enable_cmd
);
  logic [4:0] cmd = 5'h00;
  // one wire per command
  assign host_halt_cmd = cmd[0];
  assign host_go_cmd = cmd[1];
  assign single_step_command = cmd[2];
  assign tagged_resume_command = cmd[3];
  assign host_debug_enable_cmd = cmd[4];
  // one-cycle command pulse, then idle
  task automatic send(input int k);
    begin
      @(posedge ref_clk);
      cmd <= 5'h01 << k;
      @(posedge ref_clk);
      cmd <= 5'h00;
    end
  endtask
endmodule

// file: cpu_branch_bittest_stop_decode_bench.sv
// Purpose: self-checking bench for the decode block
// Assumes: apb master on ref_clk, strap raised only for the mid-run reset
// Notes: host commands come from the partner model
`timescale 1ns/1ps
`include "cpu_decode_regs.vh"

module cpu_branch_bittest_stop_decode_bench;
  logic ref_clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic irq_pin = 1'h0, wake_event = 1'h0, periodic_wake = 1'h0, security_active = 1'h0;
  logic reset_into_background = 1'h0, re, t;
  logic [7:0] paddr = 8'h00, r;
  logic [31:0] pwdata = 32'h0, rq;
  wire [31:0] prdata;
  wire pready, pslverr, host_halt_cmd, host_go_cmd, single_step_command, exec_done;
  wire tagged_resume_command, host_debug_enable_cmd, cpu_clk_run, osc_run, min_clk_run;
  wire [1:0] cpu_mode;
  int miscompares = 0, check_count = 0, ncyc;
  logic [7:0] bop [10] = '{8'h22, 8'h24, 8'h25, 8'h27, 8'h28, 8'h29, 8'h2e, 8'h2f, 8'h90, 8'h92};
  logic [7:0] fls [6] = '{8'h00, 8'h01, 8'h02, 8'h84, 8'h14, 8'h80};
  logic [15:0] xop [8] = '{16'h00a5, 16'h00b5, 16'h00c5, 16'h00d5, 16'h00e5, 16'h00f5,
    16'h9ed5, 16'h9ee5};
  int xcy [8] = '{2, 3, 4, 4, 3, 3, 5, 4};
  int xln [8] = '{2, 2, 3, 3, 2, 1, 4, 3};

  always #25 ref_clk = ~ref_clk;

  cpu_branch_bittest_stop_decode u_cpu_branch_bittest_stop_decode (.ref_clk, .rst_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq_pin, .wake_event,
    .periodic_wake, .host_halt_cmd, .host_go_cmd, .single_step_command, .tagged_resume_command,
    .host_debug_enable_cmd, .reset_into_background, .security_active, .cpu_clk_run, .osc_run,
    .min_clk_run, .cpu_mode, .exec_done);
  host_debug_model u_host_debug_model (.ref_clk, .host_halt_cmd, .host_go_cmd,
    .single_step_command, .tagged_resume_command, .host_debug_enable_cmd);
  ////////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    begin
      check_count++;
      if (seen !== exp)
      begin
        miscompares++;
        $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // one apb transfer, result left in rq and re
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge ref_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'h1;
      do
        @(posedge ref_clk);
      while (pready !== 1'h1);
      rq = prdata;
      re = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask
  // cycles until the retire pulse
  task automatic wait_done;
    begin
      ncyc = 0;
      do
      begin
        @(posedge ref_clk);
        ncyc++;
      end
      while (exec_done !== 1'h1 && ncyc < 60);
    end
  endtask
  // load operands at pc 1000 and start
  task automatic run_op(input logic [15:0] op, input logic [7:0] fl, input logic [7:0] mv,
    input logic wt);
    begin
      apb(1'h1, `OFS_OPCODE, {16'h0, op});
      apb(1'h1, `OFS_OPERAND, 32'hf0);
      apb(1'h1, `OFS_PC, 32'h1000);
      apb(1'h1, `OFS_FLAGS, {24'h0, fl});
      apb(1'h1, `OFS_ACC, 32'hc3);
      apb(1'h1, `OFS_MEM, {24'h0, mv});
      apb(1'h1, `OFS_CTRL, 32'h1);
      if (wt)
        wait_done();
    end
  endtask
  // mode and clock outputs after settling
  task automatic mchk(input logic [1:0] m, input logic c, input logic o, input logic k);
    begin
      repeat (3) @(posedge ref_clk);
      chk("mode", cpu_mode, m);
      chk("cpu clock", cpu_clk_run, c);
      chk("oscillator", osc_run, o);
      chk("min clocks", min_clk_run, k);
    end
  endtask
  // pulse external or periodic wake
  task automatic wake(input logic per);
    begin
      @(posedge ref_clk);
      wake_event <= !per;
      periodic_wake <= per;
      @(posedge ref_clk);
      wake_event <= 1'h0;
      periodic_wake <= 1'h0;
    end
  endtask
  function automatic logic exp_taken(input logic [7:0] op, input logic [7:0] f, input logic p);
    logic nv;
    begin
      nv = f[`FLG_N] ^ f[`FLG_V];
      case (op)
        8'h22: exp_taken = !(f[`FLG_C] | f[`FLG_Z]);
        8'h24: exp_taken = !f[`FLG_C];
        8'h25: exp_taken = f[`FLG_C];
        8'h27: exp_taken = f[`FLG_Z];
        8'h28: exp_taken = !f[`FLG_H];
        8'h29: exp_taken = f[`FLG_H];
        8'h2e: exp_taken = !p;
        8'h2f: exp_taken = p;
        8'h90: exp_taken = !nv;
        default: exp_taken = !(f[`FLG_Z] | nv);
      endcase
    end
  endfunction
  task automatic close_out;
    begin
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    close_out();
  end
  // main sequence
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'h1;
    for (int i = 0; i < 10; i++)
      for (int j = 0; j < 6; j++)
      begin
        irq_pin <= j[0];
        run_op({8'h00, bop[i]}, fls[j], 8'h00, 1'h1);
        t = exp_taken(bop[i], fls[j], j[0]);
        chk("branch cycles", ncyc, 4);
        apb(1'h0, `OFS_PC, 32'h0);
        chk("branch pc", rq, t ? 32'h0ff2 : 32'h1002);
        apb(1'h0, `OFS_STATUS, 32'h0);
        chk("taken", rq[1], t);
        apb(1'h0, `OFS_FLAGS, 32'h0);
        chk("branch flags", rq, fls[j]);
      end
    for (int i = 0; i < 8; i++)
    begin
      run_op({8'h00, 8'h11 + 8'(2 * i)}, 8'h97, 8'hff, 1'h1);
      chk("clear cycles", ncyc, 6);
      apb(1'h0, `OFS_MEM, 32'h0);
      chk("cleared byte", rq, {24'h0, 8'hff ^ (8'h01 << i)});
      apb(1'h0, `OFS_FLAGS, 32'h0);
      chk("clear flags", rq, 32'h97);
    end
    for (int i = 0; i < 8; i++)
    begin
      r = 8'hc3 & (i[0] ? 8'h81 : 8'h3c);
      run_op(xop[i], 8'h91, i[0] ? 8'h81 : 8'h3c, 1'h1);
      chk("test cycles", ncyc, xcy[i] + 1);
      apb(1'h0, `OFS_FLAGS, 32'h0);
      chk("test flags", rq, {24'h0, 8'h11 | {5'h0, r[7], r == 8'h00, 1'h0}});
      apb(1'h0, `OFS_PC, 32'h0);
      chk("test pc", rq, 32'h1000 + xln[i]);
      apb(1'h0, `OFS_MEM, 32'h0);
      chk("test operand", rq, {24'h0, i[0] ? 8'h81 : 8'h3c});
    end
    run_op(16'h0001, 8'h00, 8'h00, 1'h1);
    apb(1'h0, `OFS_STATUS, 32'h0);
    chk("illegal status", {ncyc[3:0], rq[2:0]}, {4'h2, 3'h4});
    apb(1'h0, `OFS_PC, 32'h0);
    chk("illegal pc", rq, 32'h1000);
    apb(1'h0, 8'h20, 32'h0);
    chk("unmapped error", re, 1'h1);
    apb(1'h1, `OFS_CTRL, 32'h4);
    mchk(`MODE_STOP, 1'h0, 1'h0, 1'h0);
    wake(1'h1);
    mchk(`MODE_STOP, 1'h0, 1'h0, 1'h0);
    wake(1'h0);
    mchk(`MODE_RUN, 1'h1, 1'h1, 1'h1);
    apb(1'h1, `OFS_CTRL, 32'h6);
    mchk(`MODE_STOP, 1'h0, 1'h0, 1'h1);
    wake(1'h1);
    mchk(`MODE_RUN, 1'h1, 1'h1, 1'h1);
    apb(1'h1, `OFS_CTRL, 32'h8);
    mchk(`MODE_WAIT, 1'h0, 1'h1, 1'h1);
    apb(1'h1, `OFS_CTRL, 32'h4);
    chk("ctrl in wait refused", re, 1'h1);
    wake(1'h1);
    mchk(`MODE_RUN, 1'h1, 1'h1, 1'h1);
    run_op(16'h0082, 8'h00, 8'h00, 1'h1);
    chk("halt op cycles", ncyc, 6);
    security_active <= 1'h1;
    u_host_debug_model.send(4);
    apb(1'h0, `OFS_STATUS, 32'h0);
    chk("secure blocks enable", rq[6:3], 4'h8);
    security_active <= 1'h0;
    u_host_debug_model.send(4);
    apb(1'h1, `OFS_CTRL, 32'h4);
    mchk(`MODE_STOP, 1'h0, 1'h1, 1'h1);
    u_host_debug_model.send(0);
    mchk(`MODE_BDM, 1'h1, 1'h1, 1'h1);
    u_host_debug_model.send(1);
    mchk(`MODE_RUN, 1'h1, 1'h1, 1'h1);
    for (int k = 2; k < 4; k++)
    begin
      run_op(16'h0082, 8'h00, 8'h00, 1'h0);
      repeat (4) @(posedge ref_clk);
      mchk(`MODE_BDM, 1'h1, 1'h1, 1'h1);
      u_host_debug_model.send(k);
      wait_done();
      apb(1'h0, `OFS_PC, 32'h0);
      chk("resume pc", rq, 32'h1001);
    end
    // second reset with the background strap high
    rst_n <= 1'h0;
    reset_into_background <= 1'h1;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'h1;
    mchk(`MODE_BDM, 1'h1, 1'h1, 1'h1);
    reset_into_background <= 1'h0;
    apb(1'h0, `OFS_STATUS, 32'h0);
    chk("strap status", rq[5:3], 3'h7);
    close_out();
  end
endmodule

bind cpu_branch_bittest_stop_decode cpu_decode_sva u_cpu_decode_sva (.ref_clk, .rst_n, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .wake_event, .host_halt_cmd,
  .host_go_cmd, .single_step_command, .tagged_resume_command, .cpu_clk_run, .osc_run,
  .min_clk_run, .cpu_mode, .exec_done);
